// File: hw/fblp_top.sv
// Block lock protection: serial command decoder, lock bits and bus slave.
module fblp_top #(
  parameter int WB_ADR_W = 8
) (
  // System clock and reset; synchronous in the core, asynchronous in the hand-over registers.
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Program and erase gate from the array sequencer.
  input wire logic pe_req_i,
  input wire logic [23:0] pe_addr_i,
  output logic pe_go_o,
  output logic pe_refused_o,
  // Serial link, clocked by the host.
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o
);

  // The bus must reach the three registers and fit the 8-bit decode.
  if (WB_ADR_W < 4 || WB_ADR_W > 8) begin : g_adr_check
    $error("WB_ADR_W must be between 4 and 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Maps an array address to the index of the lock bit that covers it.
  function automatic logic [6:0] lock_index(input logic [23:0] a);
    logic [5:0] blk;
    logic [6:0] sec;
    blk = a[fblp_pkg::FBLP_BLK_MSB:fblp_pkg::FBLP_BLK_LSB];
    sec = {3'h0, a[fblp_pkg::FBLP_SEC_MSB:fblp_pkg::FBLP_SEC_LSB]};
    if (blk == fblp_pkg::FBLP_BOTTOM_BLOCK) begin
      return sec;
    end else if (blk == fblp_pkg::FBLP_TOP_BLOCK) begin
      return fblp_pkg::FBLP_TOP_BASE + sec;
    end
    return fblp_pkg::FBLP_COARSE_BASE + {1'b0, blk};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link frame state, cleared whenever chip select is high.
  typedef struct packed {
    fblp_pkg::fblp_phase_t phase; // Position within the frame.
    logic [4:0] cnt;              // Bit counter within the phase.
    logic [23:0] sh;              // Input shift register.
    fblp_pkg::fblp_op_t op;       // Operation awaiting its address.
  } fblp_link_t;

  // Hand-over state in the link domain, kept across frames.
  typedef struct packed {
    logic req;                    // Toggles once per issued operation.
    fblp_pkg::fblp_op_t op;       // Operation, stable while handed over.
    logic [23:0] addr;            // Address, stable while handed over.
    logic bit_s1;                 // Lock answer, first sync stage.
    logic bit_s2;                 // Lock answer, second sync stage.
    logic bit_s3;                 // Lock answer, third sync stage.
  } fblp_hand_t;

  // Output drivers of the link, updated on the falling edge.
  typedef struct packed {
    logic miso;                   // Serial output bit.
    logic oe;                     // Serial output enable.
  } fblp_out_t;

  // Core state on the system clock.
  typedef struct packed {
    logic s1;                     // Request toggle, first sync stage.
    logic s2;                     // Request toggle, second sync stage.
    logic s3;                     // Request toggle, third sync stage.
    logic seen;                   // Last request toggle served.
    logic [fblp_pkg::FBLP_NUM_LOCK-1:0] lock; // Lock bits.
    logic answer;                 // Lock bit fetched for the last query.
    logic scheme;                 // Per-block scheme selected.
    logic [23:0] probe;           // Address probed over the bus.
    logic ack;                    // Bus acknowledge.
    logic [31:0] dat;             // Bus read data.
    logic go;                     // Program or erase allowed.
    logic refused;                // Program or erase refused.
  } fblp_core_t;

  fblp_link_t link;
  fblp_link_t next_link;
  fblp_hand_t hand;
  fblp_hand_t next_hand;
  fblp_out_t out;
  fblp_out_t next_out;
  fblp_core_t core;
  fblp_core_t next_core;

  ////////////////////////////////////////////////////////////////////////////
  // Frame decoder: shifts in the command and address, then issues one
  // operation by toggling the request.
  always_comb begin
    logic [23:0] sh_in;
    logic issue;
    fblp_pkg::fblp_op_t op_in;
    sh_in = {link.sh[22:0], spi_mosi_i};
    issue = 1'b0;
    op_in = fblp_pkg::FBLP_OP_NONE;
    next_link = link;
    next_link.sh = sh_in;
    next_link.cnt = link.cnt + 5'h01;
    case (link.phase)
      fblp_pkg::FBLP_PH_CMD: begin
        if (link.cnt == fblp_pkg::FBLP_CMD_LAST) begin
          next_link.cnt = 5'h00;
          next_link.phase = fblp_pkg::FBLP_PH_ADDR;
          case (sh_in[7:0])
            fblp_pkg::FBLP_CMD_LOCK: begin
              next_link.op = fblp_pkg::FBLP_OP_LOCK;
            end
            fblp_pkg::FBLP_CMD_UNLOCK: begin
              next_link.op = fblp_pkg::FBLP_OP_UNLOCK;
            end
            fblp_pkg::FBLP_CMD_QUERY_A,
            fblp_pkg::FBLP_CMD_QUERY_B: begin
              next_link.op = fblp_pkg::FBLP_OP_QUERY;
            end
            fblp_pkg::FBLP_CMD_GLOCK: begin
              issue = 1'b1;
              op_in = fblp_pkg::FBLP_OP_GLOCK;
              next_link.phase = fblp_pkg::FBLP_PH_IDLE;
            end
            fblp_pkg::FBLP_CMD_GUNLOCK: begin
              issue = 1'b1;
              op_in = fblp_pkg::FBLP_OP_GUNLOCK;
              next_link.phase = fblp_pkg::FBLP_PH_IDLE;
            end
            default: begin
              // Other commands belong to other blocks; ignore the frame.
              next_link.phase = fblp_pkg::FBLP_PH_IDLE;
            end
          endcase
        end
      end
      fblp_pkg::FBLP_PH_ADDR: begin
        // The full 24-bit address has arrived on the last bit.
        if (link.cnt == fblp_pkg::FBLP_ADDR_LAST) begin
          issue = 1'b1;
          op_in = link.op;
          next_link.cnt = 5'h00;
          if (link.op == fblp_pkg::FBLP_OP_QUERY) begin
            next_link.phase = fblp_pkg::FBLP_PH_DATA;
          end else begin
            next_link.phase = fblp_pkg::FBLP_PH_IDLE;
          end
        end
      end
      fblp_pkg::FBLP_PH_DATA: begin
        // Eight output bits, then the device falls silent.
        if (link.cnt == fblp_pkg::FBLP_OUT_LAST) begin
          next_link.phase = fblp_pkg::FBLP_PH_IDLE;
        end
      end
      fblp_pkg::FBLP_PH_IDLE: begin
        next_link.cnt = link.cnt;
      end
      default: begin
        next_link.phase = fblp_pkg::FBLP_PH_IDLE;
      end
    endcase
    // The op and address stay put until the next issue, long after the
    // core has seen the toggle, so the core may read them directly.
    next_hand = hand;
    next_hand.bit_s1 = core.answer;
    next_hand.bit_s2 = hand.bit_s1;
    next_hand.bit_s3 = hand.bit_s2;
    if (issue) begin
      next_hand.req = ~hand.req;
      next_hand.op = op_in;
      next_hand.addr = sh_in;
    end
  end

  // Frame registers; chip select high ends the frame at once.
  always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      link <= '{phase: fblp_pkg::FBLP_PH_CMD, cnt: 5'h00, sh: 24'h000000,
                op: fblp_pkg::FBLP_OP_NONE};
    end else begin
      link <= next_link;
    end
  end

  // Hand-over registers; the serial clock may be idle during reset.
  always_ff @(posedge spi_sck_i or posedge rst_i) begin
    if (rst_i) begin
      hand <= '{req: 1'b0, op: fblp_pkg::FBLP_OP_NONE, addr: 24'h000000,
                bit_s1: 1'b0, bit_s2: 1'b0, bit_s3: 1'b0};
    end else begin
      hand <= next_hand;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output field: seven zero bits, then the lock bit as the LSB. The core
  // has five serial cycles to deliver the answer before it is needed.
  always_comb begin
    next_out.oe = (link.phase == fblp_pkg::FBLP_PH_DATA);
    next_out.miso = 1'b0;
    if (link.phase == fblp_pkg::FBLP_PH_DATA &&
        link.cnt == fblp_pkg::FBLP_OUT_LAST) begin
      next_out.miso = hand.bit_s3;
    end
  end

  // Drive on the falling edge so the host samples on the rising one.
  always_ff @(negedge spi_sck_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      out <= '{miso: 1'b0, oe: 1'b0};
    end else begin
      out <= next_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core: serves handed-over operations, gates program and erase, and
  // answers the bus.
  always_comb begin
    logic event_in;
    logic prot;
    logic [6:0] idx;
    logic hit;
    logic [7:0] badr;
    event_in = (core.s2 == core.s3) && (core.s3 != core.seen);
    idx = lock_index(hand.addr);
    prot = 1'b0;
    hit = wb_cyc_i && wb_stb_i && !core.ack;
    badr = 8'h00;
    badr[WB_ADR_W-1:0] = {wb_adr_i[WB_ADR_W-1:2], 2'b00};
    next_core = core;
    next_core.s1 = hand.req;
    next_core.s2 = core.s1;
    next_core.s3 = core.s2;
    if (event_in) begin
      next_core.seen = core.s3;
      case (hand.op)
        fblp_pkg::FBLP_OP_LOCK: begin
          next_core.lock[idx] = 1'b1;
        end
        fblp_pkg::FBLP_OP_UNLOCK: begin
          next_core.lock[idx] = 1'b0;
        end
        fblp_pkg::FBLP_OP_GLOCK: begin
          next_core.lock = '1;
        end
        fblp_pkg::FBLP_OP_GUNLOCK: begin
          next_core.lock = '0;
        end
        fblp_pkg::FBLP_OP_QUERY: begin
          next_core.answer = core.lock[idx];
        end
        default: begin
          next_core.answer = core.answer;
        end
      endcase
    end
    // A refused request never raises go, so the array stays unchanged.
    prot = core.scheme && core.lock[lock_index(pe_addr_i)];
    next_core.go = pe_req_i && !prot;
    next_core.refused = pe_req_i && prot;
    // One-cycle acknowledge, dropped in the cycle after it was given.
    next_core.ack = hit;
    next_core.dat = 32'h00000000;
    if (hit) begin
      case (badr)
        fblp_pkg::FBLP_REG_CTRL: begin
          next_core.dat[fblp_pkg::FBLP_CTRL_SCHEME_BIT] = core.scheme;
          if (wb_we_i && wb_sel_i[0]) begin
            next_core.scheme = wb_dat_i[fblp_pkg::FBLP_CTRL_SCHEME_BIT];
          end
        end
        fblp_pkg::FBLP_REG_PROBE_ADDR: begin
          next_core.dat[23:0] = core.probe;
          if (wb_we_i) begin
            for (int b = 0; b < 3; b++) begin
              if (wb_sel_i[b]) begin
                next_core.probe[b*8 +: 8] = wb_dat_i[b*8 +: 8];
              end
            end
          end
        end
        fblp_pkg::FBLP_REG_PROBE_STATE: begin
          next_core.dat[fblp_pkg::FBLP_PROBE_LOCK_BIT] =
            core.lock[lock_index(core.probe)];
          next_core.dat[fblp_pkg::FBLP_PROBE_EFFECT_BIT] =
            core.scheme && core.lock[lock_index(core.probe)];
        end
        default: begin
          // Unmapped: acknowledged, reads zero, writes dropped.
          next_core.dat = 32'h00000000;
        end
      endcase
    end
  end

  // Core registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core <= '{s1: 1'b0, s2: 1'b0, s3: 1'b0, seen: 1'b0,
                lock: fblp_pkg::FBLP_LOCK_RESET,
                answer: 1'b0,
                scheme: fblp_pkg::FBLP_SCHEME_RESET,
                probe: 24'h000000, ack: 1'b0, dat: 32'h00000000,
                go: 1'b0, refused: 1'b0};
    end else begin
      core <= next_core;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, straight from flip-flops.
  assign wb_dat_o = core.dat;
  assign wb_ack_o = core.ack;
  assign pe_go_o = core.go;
  assign pe_refused_o = core.refused;
  assign spi_miso_o = out.miso;
  assign spi_miso_oe_o = out.oe;

endmodule // fblp_top

// File: hw/fblp_pkg.sv
// Constants, opcodes and types shared by the block lock protection logic.
package fblp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial command codes.
  localparam logic [7:0] FBLP_CMD_LOCK = 8'h36;
  localparam logic [7:0] FBLP_CMD_UNLOCK = 8'h39;
  localparam logic [7:0] FBLP_CMD_GLOCK = 8'h7e;
  localparam logic [7:0] FBLP_CMD_GUNLOCK = 8'h98;
  localparam logic [7:0] FBLP_CMD_QUERY_A = 8'h3c;
  localparam logic [7:0] FBLP_CMD_QUERY_B = 8'h3d;

  ////////////////////////////////////////////////////////////////////////////
  // Frame geometry, counted in serial clock cycles.
  localparam logic [4:0] FBLP_CMD_LAST = 5'h07;
  localparam logic [4:0] FBLP_ADDR_LAST = 5'h17;
  localparam logic [4:0] FBLP_OUT_LAST = 5'h07;

  ////////////////////////////////////////////////////////////////////////////
  // Lock bit layout: fine bits of block 0, fine bits of the top block,
  // then one coarse bit for each middle block.
  localparam int FBLP_NUM_LOCK = 94;
  localparam int FBLP_BLK_LSB = 16;
  localparam int FBLP_BLK_MSB = 21;
  localparam int FBLP_SEC_LSB = 12;
  localparam int FBLP_SEC_MSB = 15;
  localparam logic [5:0] FBLP_BOTTOM_BLOCK = 6'h00;
  localparam logic [5:0] FBLP_TOP_BLOCK = 6'h3f;
  localparam logic [6:0] FBLP_TOP_BASE = 7'h10;
  localparam logic [6:0] FBLP_COARSE_BASE = 7'h1f;
  localparam logic [FBLP_NUM_LOCK-1:0] FBLP_LOCK_RESET = '1;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the Wishbone bus.
  localparam logic [7:0] FBLP_REG_CTRL = 8'h00;
  localparam logic [7:0] FBLP_REG_PROBE_ADDR = 8'h04;
  localparam logic [7:0] FBLP_REG_PROBE_STATE = 8'h08;
  localparam int FBLP_CTRL_SCHEME_BIT = 2;
  localparam logic FBLP_SCHEME_RESET = 1'b0;
  localparam int FBLP_PROBE_LOCK_BIT = 0;
  localparam int FBLP_PROBE_EFFECT_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Operations handed from the link domain to the core.
  typedef enum logic [2:0] {
    FBLP_OP_NONE,
    FBLP_OP_LOCK,
    FBLP_OP_UNLOCK,
    FBLP_OP_GLOCK,
    FBLP_OP_GUNLOCK,
    FBLP_OP_QUERY
  } fblp_op_t;

  // Phases of one serial frame.
  typedef enum logic [1:0] {
    FBLP_PH_CMD,
    FBLP_PH_ADDR,
    FBLP_PH_DATA,
    FBLP_PH_IDLE
  } fblp_phase_t;

endpackage : fblp_pkg

// File: dv/fblp_top_monitor.sv
// Concurrent checks on the ports of the block lock protection top.
module fblp_top_monitor (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and gate ports.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic pe_req_i,
  input wire logic pe_go_o,
  input wire logic pe_refused_o,
  // Serial link ports.
  input wire logic spi_cs_n_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // A taken request is acknowledged on the very next edge.
  a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("bus request not acknowledged");
  // The acknowledge is a single cycle pulse.
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held too long");
  // An acknowledge always has a request behind it.
  a_ack_has_cause: assert property ($rose(wb_ack_o)
    |-> $past(wb_cyc_i && wb_stb_i)) else $error("acknowledge unasked");
  // Read data is quiet outside the acknowledge.
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero while idle");
  // Each gate request gets exactly one answer a cycle later.
  a_pe_one_answer: assert property (
    pe_req_i |=> pe_go_o ^ pe_refused_o) else $error("gate answer wrong");
  // No answer appears without a request.
  a_pe_no_spurious: assert property (
    !pe_req_i |=> !pe_go_o && !pe_refused_o) else $error("gate unasked");
  // The serial output stays low whenever it is not driven.
  a_miso_idle_low: assert property (
    !spi_miso_oe_o |-> !spi_miso_o) else $error("miso not low");
  // A deselected device stops driving the serial output.
  a_cs_stops_drive: assert property (
    spi_cs_n_i [*2] |-> !spi_miso_oe_o) else $error("miso driven");
  // A refused request is seen at least once.
  c_refused: cover property (pe_refused_o);
endmodule // fblp_top_monitor

// File: dv/fblp_spi_host.sv
// Serial host model that sends lock command frames in mode 0.
module fblp_spi_host (
  // Link lines driven by the host.
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o,
  // Serial data from the device.
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real HALF = 62.5;
  // The link clock stands still and the chip is deselected between frames.
  initial begin
    sck_o = 1'h0;
    cs_n_o = 1'h1;
    mosi_o = 1'h0;
  end
  // Sends a command, an optional address and clocks in read bits.
  task automatic frame(input logic [7:0] cmd, input logic [23:0] adr,
                       input int nad, input int nout, output logic [7:0] rx);
    logic [31:0] sh;
    sh = {cmd, adr};
    rx = 8'h00;
    // Starts off the system clock's grid so the two clocks share no edge.
    #(3.1);
    cs_n_o = 1'h0;
    #(HALF);
    for (int i = 0; i < 8 + nad + nout; i++) begin
      // Code then address go MSB first; later the line keeps moving.
      mosi_o = (i < 8 + nad) ? sh[31-i] : ~mosi_o;
      #(HALF);
      sck_o = 1'h1;
      if (i >= 8 + nad) begin
        rx = {rx[6:0], miso_i};
      end
      #(HALF);
      sck_o = 1'h0;
    end
    #(HALF);
    cs_n_o = 1'h1;
    // A released data line must not keep showing its last bit.
    mosi_o = ~mosi_o;
  endtask
endmodule // fblp_spi_host

// File: dv/fblp_top_tb.sv
// Self-checking bench for the block lock protection top.
module fblp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'h0;
  logic rst_i;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, pe_req_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [23:0] pe_addr_i = 24'h0;
  logic wb_ack_o, pe_go_o, pe_refused_o, sck, cs_n, mosi, miso, miso_oe;
  logic [93:0] lk = {94{1'h1}};
  logic scheme = 1'h0;
  logic [7:0] rx;
  logic [7:0] codes [6];
  logic [23:0] a;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  always #4 clk_i = ~clk_i;
  fblp_top fblp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pe_req_i(pe_req_i), .pe_addr_i(pe_addr_i),
    .pe_go_o(pe_go_o), .pe_refused_o(pe_refused_o), .spi_sck_i(sck),
    .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(miso_oe));
  fblp_spi_host fblp_spi_host_inst (.sck_o(sck), .cs_n_o(cs_n),
    .mosi_o(mosi), .miso_i(miso));
  // Compares one value and counts the result.
  task automatic chk(input string name, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Counts clock cycles for the watchdog.
  always @(posedge clk_i) begin
    cycles++;
  end
  // Lock bit covering an address: fine in the end blocks, coarse elsewhere.
  function automatic int idx(input logic [23:0] ad);
    if (ad[21:16] == 6'h00) return int'(ad[15:12]);
    if (ad[21:16] == 6'h3f) return 16 + int'(ad[15:12]);
    return 31 + int'(ad[21:16]);
  endfunction
  // Random address, biased toward the two finely locked blocks.
  function automatic logic [23:0] ra();
    logic [23:0] r;
    r = 24'($urandom);
    if ($urandom % 3 == 0) r[21:16] = 6'h00;
    else if ($urandom % 2 == 0) r[21:16] = 6'h3f;
    return r;
  endfunction
  // One classic bus cycle; read data lands in q at the acknowledge.
  task automatic wb(input logic we, input logic [7:0] ad,
                    input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    // Waits for the acknowledge; only the watchdog ends a hang.
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  // Checks one address through the probe registers and the gate.
  task automatic probe(input logic [23:0] ad);
    logic l;
    l = lk[idx(ad)];
    wb(1'h1, 8'h04, {8'h00, ad});
    wb(1'h0, 8'h08, 32'h0);
    chk("probe", q, {30'h0, scheme & l, l});
    @(posedge clk_i);
    pe_req_i <= 1'h1;
    pe_addr_i <= ad;
    @(posedge clk_i);
    pe_req_i <= 1'h0;
    @(posedge clk_i);
    chk("gate", {pe_refused_o, pe_go_o}, {scheme & l, ~(scheme & l)});
  endtask
  // Sends serial command k of the table and updates the expected bits.
  task automatic op(input int k, input logic [23:0] ad);
    logic [7:0] e;
    e = {7'h0, lk[idx(ad)]};
    fblp_spi_host_inst.frame(codes[k], ad, (k == 2 || k == 3) ? 0 : 24,
                             (k >= 4) ? 8 : 0, rx);
    if (k >= 4) chk("query", {24'h0, rx}, {24'h0, e});
    case (k)
      0: lk[idx(ad)] = 1'h1;
      1: lk[idx(ad)] = 1'h0;
      2: lk = {94{1'h1}};
      3: lk = {94{1'h0}};
      default: ;
    endcase
    repeat (12) @(posedge clk_i);
  endtask
  // Main sequence.
  task automatic run_tests();
    rst_i <= 1'h1;
    codes = '{fblp_pkg::FBLP_CMD_LOCK, fblp_pkg::FBLP_CMD_UNLOCK,
              fblp_pkg::FBLP_CMD_GLOCK, fblp_pkg::FBLP_CMD_GUNLOCK,
              fblp_pkg::FBLP_CMD_QUERY_A, fblp_pkg::FBLP_CMD_QUERY_B};
    void'($urandom(32'h0ab9542a));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, 8'h00, 32'h0);
    chk("ctrl_reset", q, 32'h0);
    probe(24'h000000);
    probe(24'h3ff000);
    wb(1'h0, 8'h0c, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'h1, 8'h00, 32'h4);
    scheme = 1'h1;
    wb(1'h0, 8'h00, 32'h0);
    chk("ctrl", q, 32'h4);
    $display("test reset and scheme done");
    op(1, 24'h003000);
    op(1, 24'h051234);
    probe(24'h003fff);
    probe(24'h004000);
    probe(24'h3f3000);
    probe(24'h050000);
    probe(24'h060000);
    op(4, 24'h003000);
    op(5, 24'h004000);
    op(0, 24'h003abc);
    probe(24'h003000);
    // A cut unlock frame and an unknown command must change nothing.
    fblp_spi_host_inst.frame(codes[1], 24'h000000, 16, 0, rx);
    fblp_spi_host_inst.frame(8'h06, 24'h000000, 24, 0, rx);
    repeat (12) @(posedge clk_i);
    probe(24'h000000);
    $display("test granularity done");
    for (int k = 3; k >= 2; k--) begin
      op(k, 24'h000000);
      probe(24'h000000);
      probe(24'h3ff000);
      probe(24'h2a0000);
      op(5, 24'h3fffff);
    end
    $display("test global done");
    repeat (30) begin
      a = ra();
      op(int'($urandom % 6), a);
      probe(a);
    end
    $display("test random done");
    wb(1'h1, 8'h00, 32'h0);
    scheme = 1'h0;
    op(2, 24'h000000);
    probe(24'h003abc);
    $display("test scheme off done");
    op(3, 24'h000000);
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    lk = {94{1'h1}};
    scheme = 1'h0;
    wb(1'h0, 8'h00, 32'h0);
    chk("ctrl_again", q, 32'h0);
    probe(24'h2a0000);
    op(4, 24'h3f5000);
    $display("test mid reset done");
  endtask
  // Runs the tests against a watchdog, then gives the verdict.
  initial begin
    fork
      run_tests();
      begin
        // About 50 frames of at most 650 cycles each, with margin.
        wait (cycles >= 60000);
        n_mismatch++;
        $display("watchdog expired");
      end
    join_any
    final_report();
  end
endmodule // fblp_top_tb
bind fblp_top fblp_top_monitor fblp_top_monitor_inst (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .pe_req_i(pe_req_i),
  .pe_go_o(pe_go_o), .pe_refused_o(pe_refused_o), .spi_cs_n_i(spi_cs_n_i),
  .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o));
